/* File: common/ppd_pkg.sv */
// Purpose: shared constants and helpers for the pre-pit block decoder
// Assumes: one byte per frame, document bit 5 is byte bit 7, bit 12 is byte bit 0
// Notes:   galois helpers use the field polynomial x^8+x^4+x^3+x^2+1
package ppd_pkg;

  // ==========================================================
  // frame layout
  localparam int unsigned  FRAMES       = 16;
  localparam logic [3:0]   REL_FIRST    = 4'h0;
  localparam logic [3:0]   REL_PARA_END = 4'h5;
  localparam logic [3:0]   REL_FIELD_ID = 4'h6;
  localparam logic [3:0]   REL_LAST     = 4'hF;
  localparam int unsigned  IX_ADDR0     = 0;
  localparam int unsigned  IX_APP       = 7;
  localparam int unsigned  IX_PHYS      = 8;
  localparam int unsigned  IX_LIMIT0    = 9;
  localparam int unsigned  IX_VEREXT    = 12;

  // ==========================================================
  // block identifiers
  localparam logic [7:0]   ID_DISC_INFO  = 8'h01;
  localparam logic [7:0]   ID_L1_LIMIT   = 8'h02;
  localparam logic [7:0]   ID_MAKER_1ST  = 8'h03;
  localparam logic [7:0]   ZERO_BYTE     = 8'h00;

  // ==========================================================
  // field positions inside a byte (document bit n -> byte bit 12-n)
  localparam int unsigned  APP_RSVD_BIT  = 7;
  localparam int unsigned  APP_USAGE_BIT = 6;
  localparam logic [5:0]   CLASS_SL0     = 6'h00;
  localparam logic [5:0]   CLASS_DL0     = 6'h02;
  localparam int unsigned  PHY_PITCH     = 7;
  localparam int unsigned  PHY_VELO      = 6;
  localparam int unsigned  PHY_DIAM      = 5;
  localparam int unsigned  PHY_REFL1     = 4;
  localparam int unsigned  PHY_REFL2     = 3;
  localparam int unsigned  PHY_MEDIA     = 2;
  localparam int unsigned  PHY_REREC     = 1;
  localparam int unsigned  PHY_OPPTP     = 0;
  localparam logic [3:0]   EXT_CODE_OK   = 4'h0;

  // ==========================================================
  // layer 1 limit floors
  localparam logic [23:0]  L1_FLOOR      = 24'h00332A;
  localparam logic [23:0]  L1_FLOOR_BCA  = 24'h003370;

  // ==========================================================
  // reset values and field polynomial low byte
  localparam logic [23:0]  RST_ADDR      = 24'h000000;
  localparam logic [7:0]   RST_BYTE      = 8'h00;
  localparam logic [47:0]  RST_MAKER     = 48'h000000000000;
  localparam logic [7:0]   GF_POLY_LOW   = 8'h1D;

  typedef enum logic {PPD_HUNT, PPD_COLLECT} ppd_state_t;

  // multiply by alpha
  function automatic logic [7:0] gfMulA(input logic [7:0] x);
    gfMulA = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY_LOW : RST_BYTE);
  endfunction

endpackage

/* File: hdl/ppd_rs_synd.sv */
// Purpose: three running syndromes (roots alpha^0..alpha^2) over one code part
// Assumes: bytes arrive highest degree first, start marks the first byte
// Notes:   okNow looks at the updated value so the last byte counts
`timescale 1ns/1ns
module ppd_rs_synd
  import ppd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       shift,
  input  wire logic       start,
  input  wire logic [7:0] data,
  output logic            okNow
);

  logic [7:0] s0_ff;
  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  logic [7:0] nxt_s0;
  logic [7:0] nxt_s1;
  logic [7:0] nxt_s2;

  // ==========================================================
  // horner step per root
  assign nxt_s0 = (start ? RST_BYTE : s0_ff) ^ data;
  assign nxt_s1 = (start ? RST_BYTE : gfMulA(s1_ff)) ^ data;
  assign nxt_s2 = (start ? RST_BYTE : gfMulA(gfMulA(s2_ff))) ^ data;
  assign okNow  = (nxt_s0 == RST_BYTE) && (nxt_s1 == RST_BYTE) && (nxt_s2 == RST_BYTE);

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      s0_ff <= RST_BYTE;
      s1_ff <= RST_BYTE;
      s2_ff <= RST_BYTE;
    end
    else if (shift)
    begin
      s0_ff <= nxt_s0;
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end

endmodule // ppd_rs_synd

/* File: hdl/ppd_decoder.sv */
// Purpose: frame a pre-pit block, check parities, decode info, limit and maker blocks
// Assumes: frame inputs come from detector logic on clk, one frame per clock with frameValid high
// Notes:   decoded outputs change only on a block that passed every check
`timescale 1ns/1ns

// Functional notes
// - application code bit 5 must be zero; bit 6 selects restricted or unrestricted
// - restricted: class 000000 single layer, 000010 dual layer, else special purpose
// - unrestricted: class other than 000000 is flagged unsupported
// - physical code bit 5 must be one, bit 6 must be zero
// - physical code bit 7 gives diameter flag: one means 80 mm
// - physical code bit 8 one, bit 9 zero; otherwise nonconforming
// - physical code bit 10 reported as phase change media flag
// - physical code bits 11 and 12 must be one; zero is flagged
// - layer 0 last address assembled from frames 9 to 11 as 24 bits
// - blocks beyond layer 0 limit still accepted; no address filtering
// - version nibble exposed and compared with compatible version input
// - extension nibble other than 0000 flagged as prohibited
// - frames 0-2 hold block address msb first, 3-5 parity A
// - id 02: frames 7, 8, 12 zero, 9-11 layer 1 limit
// - blocks beyond layer 1 limit still accepted; no address filtering
// - layer 1 limit below 00332A raises range error
// - with inner barcode option, limit below 003370 raises range error
// - id 03: maker bytes one to six in frames 7 to 12
// - maker bytes passed through unchecked
// - block framing aligns on sync code at frame start
// - frames carry relative numbers 0 to 15 in order, unprotected
// - id 01: app code 7, physical 8, address 9-11, version/extension 12
// - parity A over bytes 0-2, parity B over bytes 6-12, roots alpha^0..2
module ppd_decoder
  import ppd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        frameValid,
  input  wire logic        frameSync,
  input  wire logic [3:0]  frameRel,
  input  wire logic [7:0]  frameByte,
  input  wire logic        barcodeOpt,
  input  wire logic [3:0]  compatVer,
  output logic             blockValid,
  output logic             blockErr,
  output logic [7:0]       blockId,
  output logic [23:0]      blockAddr,
  output logic             infoValid,
  output logic             appUnrestricted,
  output logic [5:0]       appClass,
  output logic             appDualLayer,
  output logic             appSpecial,
  output logic             appUnsupported,
  output logic             appRsvdErr,
  output logic             diam80,
  output logic             phaseChange,
  output logic             physErr,
  output logic [23:0]      l0Limit,
  output logic [3:0]       versionNum,
  output logic             versionMismatch,
  output logic             extErr,
  output logic             l1Valid,
  output logic [23:0]      l1Limit,
  output logic             l1RangeErr,
  output logic             l1FillErr,
  output logic             makerValid,
  output logic [47:0]      makerId
);

  // ==========================================================
  // framing state
  ppd_state_t  state_ff;
  ppd_state_t  nxt_state;
  logic [3:0]  expect_ff;
  logic        parAOk_ff;
  logic [7:0]  rxByte_ff [FRAMES];

  logic        syncStart;
  logic        inOrder;
  logic        take;
  logic        orderBad;
  logic        synAOk;
  logic        synBOk;
  logic        partBByte;
  logic        lastFrame;
  logic        commit;
  logic        failNow;

  assign syncStart = frameValid && frameSync && (frameRel == REL_FIRST);
  assign inOrder   = frameValid && !frameSync && (state_ff == PPD_COLLECT)
                     && (frameRel == expect_ff);
  assign take      = syncStart || inOrder;
  // a sync with a nonzero number, or a gap while collecting, kills the block
  assign orderBad  = frameValid && (frameSync ? (frameRel != REL_FIRST)
                     : ((state_ff == PPD_COLLECT) && (frameRel != expect_ff)));
  assign partBByte = frameRel >= REL_FIELD_ID;
  assign lastFrame = inOrder && (frameRel == REL_LAST);
  assign commit    = lastFrame && parAOk_ff && synBOk;
  // a fresh sync mid-block drops the partial block
  assign failNow   = orderBad || (lastFrame && !(parAOk_ff && synBOk))
                     || (syncStart && (state_ff == PPD_COLLECT));

  always_comb
  begin
    nxt_state = state_ff;
    if (syncStart)
      nxt_state = PPD_COLLECT;
    else if (orderBad || lastFrame)
      nxt_state = PPD_HUNT;
  end

  // ==========================================================
  // parity checkers
  ppd_rs_synd uSynA (
    .clk   (clk),
    .rst_n (rst_n),
    .shift (take && !partBByte),
    .start (syncStart),
    .data  (frameByte),
    .okNow (synAOk)
  );

  ppd_rs_synd uSynB (
    .clk   (clk),
    .rst_n (rst_n),
    .shift (take && partBByte),
    .start (take && (frameRel == REL_FIELD_ID)),
    .data  (frameByte),
    .okNow (synBOk)
  );

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      state_ff  <= PPD_HUNT;
      expect_ff <= REL_FIRST;
      parAOk_ff <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      expect_ff <= take ? frameRel + 4'h1 : expect_ff;
      if (take && (frameRel == REL_PARA_END))
        parAOk_ff <= synAOk;
      else if (syncStart)
        parAOk_ff <= 1'b0;
    end

  // raw bytes, data only so no reset needed
  always_ff @(posedge clk)
    if (take)
      rxByte_ff[frameRel] <= frameByte;

  // ==========================================================
  // field decode from the stored bytes
  logic [7:0]  idByte;
  logic [7:0]  appByte;
  logic [7:0]  phyByte;
  logic [7:0]  verExt;
  logic [23:0] addrWord;
  logic [23:0] limitWord;
  logic [47:0] makerWord;
  logic        isInfo;
  logic        isL1;
  logic        isMaker;
  logic [5:0]  classCode;
  logic        unrestr;
  logic        physBad;
  logic        l1Low;
  logic        fillBad;

  assign idByte    = rxByte_ff[REL_FIELD_ID];
  assign appByte   = rxByte_ff[IX_APP];
  assign phyByte   = rxByte_ff[IX_PHYS];
  assign verExt    = rxByte_ff[IX_VEREXT];
  assign addrWord  = {rxByte_ff[IX_ADDR0], rxByte_ff[IX_ADDR0+1], rxByte_ff[IX_ADDR0+2]};
  assign limitWord = {rxByte_ff[IX_LIMIT0], rxByte_ff[IX_LIMIT0+1], rxByte_ff[IX_LIMIT0+2]};
  assign makerWord = {rxByte_ff[7], rxByte_ff[8], rxByte_ff[9],
                      rxByte_ff[10], rxByte_ff[11], rxByte_ff[12]};
  assign isInfo    = idByte == ID_DISC_INFO;
  assign isL1      = idByte == ID_L1_LIMIT;
  assign isMaker   = idByte == ID_MAKER_1ST;
  assign classCode = appByte[5:0];
  assign unrestr   = appByte[APP_USAGE_BIT];
  assign physBad   = !phyByte[PHY_PITCH] || phyByte[PHY_VELO]
                     || !phyByte[PHY_REFL1] || phyByte[PHY_REFL2]
                     || !phyByte[PHY_REREC] || !phyByte[PHY_OPPTP];
  // option raises the floor, so either comparison alone decides
  assign l1Low     = (limitWord < L1_FLOOR)
                     || (barcodeOpt && (limitWord < L1_FLOOR_BCA));
  assign fillBad   = (rxByte_ff[7] != ZERO_BYTE) || (rxByte_ff[8] != ZERO_BYTE)
                     || (rxByte_ff[12] != ZERO_BYTE);

  // ==========================================================
  // strobes and common block outputs
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      blockValid <= 1'b0;
      blockErr   <= 1'b0;
      infoValid  <= 1'b0;
      l1Valid    <= 1'b0;
      makerValid <= 1'b0;
      blockId    <= RST_BYTE;
      blockAddr  <= RST_ADDR;
    end
    else
    begin
      blockValid <= commit;
      blockErr   <= failNow;
      infoValid  <= commit && isInfo;
      l1Valid    <= commit && isL1;
      makerValid <= commit && isMaker;
      // no address window check: out-of-zone blocks stay valid
      if (commit)
      begin
        blockId   <= idByte;
        blockAddr <= addrWord;
      end
    end

  // ==========================================================
  // disc information outputs
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      appUnrestricted <= 1'b0;
      appClass        <= CLASS_SL0;
      appDualLayer    <= 1'b0;
      appSpecial      <= 1'b0;
      appUnsupported  <= 1'b0;
      appRsvdErr      <= 1'b0;
      diam80          <= 1'b0;
      phaseChange     <= 1'b0;
      physErr         <= 1'b0;
      l0Limit         <= RST_ADDR;
      versionNum      <= EXT_CODE_OK;
      versionMismatch <= 1'b0;
      extErr          <= 1'b0;
    end
    else if (commit && isInfo)
    begin
      appUnrestricted <= unrestr;
      appClass        <= classCode;
      appDualLayer    <= !unrestr && (classCode == CLASS_DL0);
      appSpecial      <= !unrestr && (classCode != CLASS_DL0) && (classCode != CLASS_SL0);
      appUnsupported  <= unrestr && (classCode != CLASS_SL0);
      appRsvdErr      <= appByte[APP_RSVD_BIT];
      diam80          <= phyByte[PHY_DIAM];
      phaseChange     <= phyByte[PHY_MEDIA];
      physErr         <= physBad;
      l0Limit         <= limitWord;
      versionNum      <= verExt[7:4];
      versionMismatch <= verExt[7:4] != compatVer;
      extErr          <= verExt[3:0] != EXT_CODE_OK;
    end

  // ==========================================================
  // layer 1 limit and maker outputs
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      l1Limit    <= RST_ADDR;
      l1RangeErr <= 1'b0;
      l1FillErr  <= 1'b0;
      makerId    <= RST_MAKER;
    end
    else
    begin
      if (commit && isL1)
      begin
        l1Limit    <= limitWord;
        l1RangeErr <= l1Low;
        l1FillErr  <= fillBad;
      end
      // opaque bytes, never interpreted here
      if (commit && isMaker)
        makerId <= makerWord;
    end

endmodule // ppd_decoder

/* File: tb/ppd_decoder_asserts.sv */
// Purpose: concurrent checks on the decoder ports
// Assumes: one clock, async active-low reset
// Notes:   pulses and held fields tied to their causes
`timescale 1ns/1ns
module ppd_decoder_asserts
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        frameValid,
  input wire logic [3:0]  frameRel,
  input wire logic        barcodeOpt,
  input wire logic        blockValid,
  input wire logic        blockErr,
  input wire logic [7:0]  blockId,
  input wire logic [23:0] blockAddr,
  input wire logic        infoValid,
  input wire logic        l1Valid,
  input wire logic        makerValid,
  input wire logic        appUnrestricted,
  input wire logic [5:0]  appClass,
  input wire logic        appDualLayer,
  input wire logic        appSpecial,
  input wire logic        appUnsupported,
  input wire logic [23:0] l0Limit,
  input wire logic [23:0] l1Limit,
  input wire logic        l1RangeErr
);
  import ppd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====================
  // pulses
  chk_pulse_excl: assert property (!(blockValid && blockErr))
    else $error("accept and discard together");
  chk_after_last: assert property (blockValid |-> $past(frameValid) && $past(frameRel) == REL_LAST)
    else $error("accept not after last frame");
  chk_info_pulse: assert property (infoValid |-> blockValid && blockId == ID_DISC_INFO)
    else $error("info pulse without info block");
  chk_limit_pulse: assert property (l1Valid |-> blockValid && blockId == ID_L1_LIMIT)
    else $error("limit pulse without limit block");
  chk_maker_pulse: assert property (makerValid |-> blockValid && blockId == ID_MAKER_1ST)
    else $error("maker pulse without maker block");
  chk_info_once: assert property (infoValid |=> !infoValid)
    else $error("info pulse too long");
  // ====================
  // decoded fields
  chk_dual_layer: assert property (appDualLayer == (!appUnrestricted && appClass == CLASS_DL0))
    else $error("dual layer flag wrong");
  chk_special_class: assert property (appSpecial == (!appUnrestricted && appClass != CLASS_SL0 && appClass != CLASS_DL0))
    else $error("special flag wrong");
  chk_unsup_class: assert property (appUnsupported == (appUnrestricted && appClass != CLASS_SL0))
    else $error("unsupported flag wrong");
  // option is judged as it stood at the commit edge, one cycle before the pulse
  chk_range_floor: assert property (l1Valid |-> l1RangeErr == (l1Limit < L1_FLOOR || ($past(barcodeOpt) && l1Limit < L1_FLOOR_BCA)))
    else $error("range flag wrong");
  chk_l0_hold: assert property (!infoValid |-> $stable(l0Limit))
    else $error("layer 0 limit moved");
  chk_addr_on_err: assert property (blockErr |-> $stable(blockAddr))
    else $error("address moved on discard");
endmodule // ppd_decoder_asserts

bind ppd_decoder ppd_decoder_asserts i_ppd_decoder_asserts (.*);

/* File: tb/ppd_detector_model.sv */
// Purpose: detector stand-in, sends one block per call
// Assumes: frames driven 1 ns after the rising edge
// Notes:   idle byte inverted so no stale value reads as data
`timescale 1ns/1ns
module ppd_detector_model
(
  input  wire logic  clk,
  output logic       frameValid,
  output logic       frameSync,
  output logic [3:0] frameRel,
  output logic [7:0] frameByte
);
  initial
  begin
    frameValid = 1'b0;
    frameSync = 1'b0;
    frameRel = 4'h0;
    frameByte = 8'h00;
  end
  // ====================
  // own field arithmetic, kept apart from the design
  function automatic logic [7:0] mulG(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int k = 7; k >= 0; k--)
      p = {p[6:0], 1'b0} ^ (p[7] ? 8'h1D : 8'h00) ^ (b[k] ? a : 8'h00);
    return p;
  endfunction
  // remainder of I(x)x^3 by (x+1)(x+a)(x+a^2)
  function automatic logic [23:0] rsPar(input logic [7:0] c[16], input int lo, input int hi);
    logic [23:0] r;
    logic [7:0]  fb;
    r = 24'h000000;
    for (int j = lo; j <= hi; j++)
    begin
      fb = c[j] ^ r[23:16];
      r = {r[15:8] ^ mulG(fb, 8'h07), r[7:0] ^ mulG(fb, 8'h0E), mulG(fb, 8'h08)};
    end
    return r;
  endfunction
  // ====================
  // block sender; relBad cuts the block short after a misnumbered frame
  task automatic sendBlock(input logic [7:0] id, input logic [47:0] body, input logic [23:0] addr,
                           input logic [7:0] parFlip, input int relBad, input logic withSync);
    logic [7:0] c[16];
    {c[0], c[1], c[2]} = addr;
    {c[3], c[4], c[5]} = rsPar(c, 0, 2) ^ {parFlip, 16'h0000};
    c[6] = id;
    {c[7], c[8], c[9], c[10], c[11], c[12]} = body;
    {c[13], c[14], c[15]} = rsPar(c, 6, 12);
    for (int i = 0; i < 16 && i <= relBad; i++)
    begin
      @(posedge clk);
      #1;
      frameValid = 1'b1;
      frameSync = withSync && i == 0;
      frameRel = (i == relBad) ? 4'(i + 3) : 4'(i);
      frameByte = c[i];
    end
    @(posedge clk);
    #1;
    frameValid = 1'b0;
    frameSync = 1'b0;
    frameByte = ~frameByte;
  endtask
endmodule // ppd_detector_model

/* File: tb/ppd_decoder_tb_top.sv */
// Purpose: self-checking bench for the pre-pit block decoder
// Assumes: detector model delivers whole blocks, or one cut short after a misnumbered frame
// Notes:   each check on a block lands in the cycle after its last frame; the reset checks land right after reset
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module ppd_decoder_tb_top;
  import ppd_pkg::*;
  logic        clk, rst_n, barcodeOpt, frameValid, frameSync, blockValid, blockErr, infoValid, l1Valid, makerValid;
  logic        appUnrestricted, appDualLayer, appSpecial, appUnsupported, appRsvdErr, diam80, phaseChange, physErr;
  logic        versionMismatch, extErr, l1RangeErr, l1FillErr;
  logic [3:0]  compatVer, frameRel, versionNum;
  logic [7:0]  frameByte, blockId;
  logic [5:0]  appClass;
  logic [23:0] blockAddr, l0Limit, l1Limit;
  logic [47:0] makerId;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  ppd_decoder        i_ppd_decoder (.*);
  ppd_detector_model i_ppd_detector_model (.*);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, whole run is a few hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      test_done();
    end
  end
  // ====================
  // scenarios
  task automatic blk(input logic [7:0] id, input logic [47:0] body, input logic [23:0] addr = 24'hFFCFFF,
                     input logic [7:0] flip = 8'h00, input int bad = 16, input logic sy = 1'b1);
    i_ppd_detector_model.sendBlock(id, body, addr, flip, bad, sy);
  endtask
  task automatic t_info();
    blk(ID_DISC_INFO, 48'h02B7FDD10A50);
    `CHK("infoValid", 1'b1, infoValid)
    `CHK("blockAddr", 24'hFFCFFF, blockAddr)
    `CHK("appDualLayer", 1'b1, appDualLayer)
    `CHK("diam80", 1'b1, diam80)
    `CHK("phaseChange", 1'b1, phaseChange)
    `CHK("physErr", 1'b0, physErr)
    `CHK("l0Limit", 24'hFDD10A, l0Limit)
    `CHK("versionMismatch", 1'b0, versionMismatch)
    `CHK("extErr", 1'b0, extErr)
    // physical byte breaks only the second reflectivity bit
    blk(ID_DISC_INFO, 48'hC39FFDD10A61, 24'hFDD000);
    `CHK("blockValid", 1'b1, blockValid)
    `CHK("appRsvdErr", 1'b1, appRsvdErr)
    `CHK("appUnrestricted", 1'b1, appUnrestricted)
    `CHK("appClass", 6'h03, appClass)
    `CHK("appUnsupported", 1'b1, appUnsupported)
    `CHK("versionMismatch", 1'b1, versionMismatch)
    `CHK("physErr", 1'b1, physErr)
    `CHK("diam80", 1'b0, diam80)
    `CHK("versionNum", 4'h6, versionNum)
    `CHK("extErr", 1'b1, extErr)
    blk(ID_DISC_INFO, 48'h05B6FDD10A50);
    `CHK("appSpecial", 1'b1, appSpecial)
    `CHK("physErr", 1'b1, physErr)
    // only the track pitch bit is wrong here
    blk(ID_DISC_INFO, 48'h0037FDD10A50);
    `CHK("physErr", 1'b1, physErr)
    `CHK("appUnrestricted", 1'b0, appUnrestricted)
    `CHK("appDualLayer", 1'b0, appDualLayer)
    `CHK("appSpecial", 1'b0, appSpecial)
    `CHK("diam80", 1'b1, diam80)
    $display("t_info done");
  endtask
  task automatic t_limit();
    logic [23:0] lim[4];
    lim = '{24'h003329, 24'h00332A, 24'h00336F, 24'h003370};
    for (int k = 0; k < 4; k++)
    begin
      barcodeOpt = k >= 2;
      blk(ID_L1_LIMIT, {16'h0000, lim[k], 8'h00}, 24'h00FFF0);
      `CHK("l1Valid", 1'b1, l1Valid)
      `CHK("l1Limit", lim[k], l1Limit)
      `CHK("l1RangeErr", k % 2 == 0, l1RangeErr)
    end
    blk(ID_L1_LIMIT, {16'h0100, 24'h004000, 8'h00});
    `CHK("l1FillErr", 1'b1, l1FillErr)
    `CHK("l0Limit", 24'hFDD10A, l0Limit)
    $display("t_limit done");
  endtask
  task automatic t_maker();
    blk(ID_MAKER_1ST, 48'hA1B2C3D4E5F6);
    `CHK("makerValid", 1'b1, makerValid)
    `CHK("makerId", 48'hA1B2C3D4E5F6, makerId)
    blk(8'h04, 48'h000000000000);
    `CHK("blockId", 8'h04, blockId)
    `CHK("makerValid", 1'b0, makerValid)
    $display("t_maker done");
  endtask
  task automatic t_bad();
    blk(ID_MAKER_1ST, 48'h111111111111, 24'hFFCFFF, 8'h01);
    `CHK("blockErr", 1'b1, blockErr)
    `CHK("makerId", 48'hA1B2C3D4E5F6, makerId)
    blk(ID_MAKER_1ST, 48'h222222222222, 24'hFFCFFF, 8'h00, 7);
    `CHK("blockErr", 1'b1, blockErr)
    blk(ID_MAKER_1ST, 48'h333333333333, 24'hFFCFFF, 8'h00, 16, 1'b0);
    `CHK("blockValid", 1'b0, blockValid)
    `CHK("blockErr", 1'b0, blockErr)
    blk(ID_MAKER_1ST, 48'h444444444444);
    `CHK("makerId", 48'h444444444444, makerId)
    $display("t_bad done");
  endtask
  task automatic t_reset();
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    `CHK("makerId", 48'h000000000000, makerId)
    `CHK("l1Limit", 24'h000000, l1Limit)
    blk(ID_DISC_INFO, 48'h02B7FDD10A50);
    `CHK("infoValid", 1'b1, infoValid)
    $display("t_reset done");
  endtask
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ====================
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    barcodeOpt = 1'b0;
    compatVer = 4'h5;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_info();
    t_limit();
    t_maker();
    t_bad();
    t_reset();
    test_done();
  end
endmodule // ppd_decoder_tb_top
